// ==== hdl/mrc_pkg.sv ====
// Constants, types and helpers shared by the receive control block
// Assumes one core clock; all offsets are byte addresses on a 32-bit bus
package mrc_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [15:0] ADDR_CAUSE = 16'h00C0;
    localparam logic [15:0] ADDR_MASK = 16'h00D0;
    localparam logic [15:0] ADDR_CTRL = 16'h0100;
    localparam logic [15:0] ADDR_RING = 16'h2808;
    localparam logic [15:0] ADDR_MTA = 16'h5200;
    localparam logic [15:0] ADDR_MTA_LAST = 16'h53FC;
    localparam logic [15:0] ADDR_STA_LO = 16'h5400;
    localparam logic [15:0] ADDR_STA_HI = 16'h5404;

    // ==========================================================
    // Receive control field positions and reset values
    localparam int CTRL_EN_BIT = 1;
    localparam int CTRL_SBP_BIT = 2;
    localparam int CTRL_UPE_BIT = 3;
    localparam int CTRL_MPE_BIT = 4;
    localparam int CTRL_LPE_BIT = 5;
    localparam int CTRL_THR_LO = 8;
    localparam int CTRL_DESC_LO = 10;
    localparam int CTRL_MO_LO = 12;
    localparam int CTRL_BAM_BIT = 15;
    localparam logic [31:0] CTRL_WR_MASK = 32'h0000BF3E;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam int CAUSE_MIN_THR_BIT = 4;
    localparam logic [15:0] RING_RESET = 16'h0000;
    localparam logic [47:0] STA_RESET = 48'h000000000000;

    // ==========================================================
    // Frame limits and address classes
    localparam logic [15:0] LONG_LEN = 16'h05F2; // 1522 bytes
    localparam logic [15:0] MAX_LEN = 16'h4000; // 16384 bytes
    localparam int DA_GROUP_BIT = 40;
    localparam logic [47:0] DA_BCAST = 48'hFFFFFFFFFFFF;
    localparam int MTA_WORDS = 128;

    // ==========================================================
    // Field encodings
    localparam logic [1:0] THR_HALF = 2'h0;
    localparam logic [1:0] THR_QUARTER = 2'h1;
    localparam logic [1:0] THR_EIGHTH = 2'h2;
    localparam logic [1:0] DESC_LEGACY = 2'h0;
    localparam logic [1:0] DESC_SPLIT = 2'h1;
    localparam logic [1:0] MO_47_36 = 2'h0;
    localparam logic [1:0] MO_46_35 = 2'h1;
    localparam logic [1:0] MO_45_34 = 2'h2;

    typedef enum logic [1:0] {
        MRC_IDLE = 2'b00,
        MRC_FRAME = 2'b01,
        MRC_EVAL = 2'b11
    } mrc_state_e;

    // Frame events from the receive decoder
    typedef struct packed {
        logic start;
        logic sfd_ok;
        logic [47:0] da;
        logic err;
        logic last;
        logic [15:0] len;
    } mrc_frame_s;

    // Per-frame outcome pulses
    typedef struct packed {
        logic deliver;
        logic drop;
        logic mng;
        logic stat;
        logic bad;
        logic long_pkt;
    } mrc_verdict_s;

    // Byte-enable merge of a write into an old word
    function automatic logic [31:0] mrc_be_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                                 input logic [3:0] be);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

// ==== hdl/mrc_mcast_filter.sv ====
// Multicast filter table: 4096 bits held as 32-bit words, with lookup
// Assumes writes come from the bus slave on the same clock
`timescale 1ns/10ps
module mrc_mcast_filter #(
    parameter int WORDS = mrc_pkg::MTA_WORDS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Table write and read-back
    input wire logic wr_en_i,
    input wire logic [6:0] wr_idx_i,
    input wire logic [31:0] wr_data_i,
    input wire logic [3:0] wr_be_i,
    input wire logic [6:0] rd_idx_i,
    output logic [31:0] rd_data_o,
    // Lookup
    input wire logic [47:0] da_i,
    input wire logic [1:0] offset_i,
    output logic hit_o
);

    typedef struct packed {
        logic [WORDS-1:0][31:0] words;
        logic hit;
    } mrc_mta_s;

    mrc_mta_s mta_reg;
    mrc_mta_s mta_next;
    logic [11:0] index;

    // ==========================================================
    // Index slice from the destination address
    function automatic logic [11:0] mrc_mta_index(input logic [47:0] da, input logic [1:0] mo);
        logic [11:0] idx;
        idx = da[43:32];
        case (mo)
            mrc_pkg::MO_47_36: idx = da[47:36];
            mrc_pkg::MO_46_35: idx = da[46:35];
            mrc_pkg::MO_45_34: idx = da[45:34];
            default: idx = da[43:32];
        endcase
        return idx;
    endfunction

    assign index = mrc_mta_index(da_i, offset_i);
    assign rd_data_o = mta_reg.words[rd_idx_i];
    assign hit_o = mta_reg.hit;

    // Table update and registered bit lookup
    always_comb
    begin
        mta_next = mta_reg;
        mta_next.hit = mta_reg.words[index[11:5]][index[4:0]];
        if (wr_en_i)
        begin
            mta_next.words[wr_idx_i] = mrc_pkg::mrc_be_merge(mta_reg.words[wr_idx_i], wr_data_i, wr_be_i);
        end
    end

    // Cleared table rejects all multicast until software fills it
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            mta_reg <= '0;
        end
        else
        begin
            mta_reg <= mta_next;
        end
    end

endmodule // mrc_mcast_filter

// ==== hdl/mrc_rx_control.sv ====
// Receive control of an Ethernet MAC: control register, frame admission, threshold cause
// Assumes frame events come from a decoder on clk_i and free count from the DMA on clk_i
// Function
// - Deliver to host only while enable set
// - Clearing enable finishes the current packet
// - Packets arriving while disabled are dropped
// - Statistics count regardless of enable
// - Store bad packets when its bit set
// - Errors ahead of delimiter are ignored
// - Frames need a valid start delimiter
// - Bad packets never go to manageability
// - Long packets dropped unless long enable
// - Long means more than 1522 bytes
// - Long enable admits up to 16384 bytes
// - Cause set when free count hits threshold
// - Descriptor format legacy or split
// - Multicast table indexed by 12-bit slice
// - Offsets 0-2 pick bits 47:36, 46:35, 45:34
// - Offset 3 picks bits 43:32
// - Broadcast accept passes all broadcasts
// - Threshold interrupt gated by mask bit
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
module mrc_rx_control (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Avalon-MM slave
    input wire logic [15:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Frame events and DMA state
    input wire mrc_pkg::mrc_frame_s frame_i,
    input wire logic [15:0] free_desc_i,
    // Outcomes
    output mrc_pkg::mrc_verdict_s verdict_o,
    output logic [1:0] rx_descriptor_format_o,
    output logic rx_min_threshold_irq_o
);

    typedef struct packed {
        logic [31:0] ctrl;
        logic cause;
        logic mask;
        logic [15:0] ring;
        logic [47:0] sta;
        mrc_pkg::mrc_state_e st;
        logic [47:0] da;
        logic dma_on;
        logic err;
        logic [15:0] len;
        mrc_pkg::mrc_verdict_s verdict;
        logic waitreq;
        logic [31:0] rdata;
        logic thr_eq;
        logic irq;
        logic [1:0] desc;
    } mrc_state_s;

    mrc_state_s s_reg;
    mrc_state_s s_next;
    logic [15:0] addr_w;
    logic [15:0] mta_off;
    logic in_mta;
    logic req;
    logic wr_done;
    logic [31:0] mta_rd;
    logic mc_hit;
    logic [15:0] thr;
    logic thr_eq;
    logic thr_set;

    // ==========================================================
    // Free descriptor threshold
    function automatic logic [15:0] mrc_threshold(input logic [15:0] ring, input logic [1:0] sel);
        logic [15:0] t;
        t = 16'h0000;
        case (sel)
            mrc_pkg::THR_HALF: t = ring >> 1;
            mrc_pkg::THR_QUARTER: t = ring >> 2;
            mrc_pkg::THR_EIGHTH: t = ring >> 3;
            default: t = 16'h0000;
        endcase
        return t;
    endfunction

    // ==========================================================
    // Bus decode
    assign addr_w = {avs_address_i[15:2], 2'b00};
    assign mta_off = addr_w - mrc_pkg::ADDR_MTA;
    assign in_mta = (addr_w >= mrc_pkg::ADDR_MTA) && (addr_w <= mrc_pkg::ADDR_MTA_LAST);
    assign req = avs_read_i || avs_write_i;
    // A write lands only on the edge where waitrequest is seen low
    assign wr_done = avs_write_i && !s_reg.waitreq;

    // Reserved code 11 and an empty ring never match
    assign thr = mrc_threshold(s_reg.ring, s_reg.ctrl[mrc_pkg::CTRL_THR_LO +: 2]);
    assign thr_eq = (s_reg.ctrl[mrc_pkg::CTRL_THR_LO +: 2] != 2'h3) && (s_reg.ring != 16'h0000)
                    && (free_desc_i == thr);
    assign thr_set = thr_eq && !s_reg.thr_eq;

    mrc_mcast_filter #(
        .WORDS(mrc_pkg::MTA_WORDS)
    ) u_mta (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(wr_done && in_mta),
        .wr_idx_i(mta_off[8:2]),
        .wr_data_i(avs_writedata_i),
        .wr_be_i(avs_byteenable_i),
        .rd_idx_i(mta_off[8:2]),
        .rd_data_o(mta_rd),
        .da_i(s_reg.da),
        .offset_i(s_reg.ctrl[mrc_pkg::CTRL_MO_LO +: 2]),
        .hit_o(mc_hit)
    );

    // ==========================================================
    // Next state: bus slave, cause, frame admission
    always_comb
    begin
        logic is_bc;
        logic is_mc;
        logic addr_ok;
        logic long_pkt;
        logic len_ok;
        is_bc = (s_reg.da == mrc_pkg::DA_BCAST);
        is_mc = s_reg.da[mrc_pkg::DA_GROUP_BIT];
        addr_ok = 1'b0;
        long_pkt = 1'b0;
        len_ok = 1'b0;
        s_next = s_reg;
        s_next.verdict = '0;

        // One wait cycle, then the answer stands for one cycle
        if (req && s_reg.waitreq)
        begin
            s_next.waitreq = 1'b0;
            s_next.rdata = 32'h00000000;
            if (avs_read_i)
            begin
                if (in_mta)
                begin
                    s_next.rdata = mta_rd;
                end
                else
                begin
                    case (addr_w)
                        mrc_pkg::ADDR_CTRL: s_next.rdata = s_reg.ctrl;
                        mrc_pkg::ADDR_CAUSE: s_next.rdata[mrc_pkg::CAUSE_MIN_THR_BIT] = s_reg.cause;
                        mrc_pkg::ADDR_MASK: s_next.rdata[mrc_pkg::CAUSE_MIN_THR_BIT] = s_reg.mask;
                        mrc_pkg::ADDR_RING: s_next.rdata[15:0] = s_reg.ring;
                        mrc_pkg::ADDR_STA_LO: s_next.rdata = s_reg.sta[31:0];
                        mrc_pkg::ADDR_STA_HI: s_next.rdata[15:0] = s_reg.sta[47:32];
                        default: s_next.rdata = 32'h00000000;
                    endcase
                end
            end
        end
        else
        begin
            s_next.waitreq = 1'b1;
        end

        // Register writes; reserved control bits are never stored
        if (wr_done)
        begin
            case (addr_w)
                mrc_pkg::ADDR_CTRL:
                begin
                    s_next.ctrl = mrc_pkg::mrc_be_merge(s_reg.ctrl, avs_writedata_i, avs_byteenable_i)
                                  & mrc_pkg::CTRL_WR_MASK;
                end
                mrc_pkg::ADDR_MASK:
                begin
                    if (avs_byteenable_i[0])
                    begin
                        s_next.mask = avs_writedata_i[mrc_pkg::CAUSE_MIN_THR_BIT];
                    end
                end
                mrc_pkg::ADDR_CAUSE:
                begin
                    if (avs_byteenable_i[0] && avs_writedata_i[mrc_pkg::CAUSE_MIN_THR_BIT])
                    begin
                        s_next.cause = 1'b0;
                    end
                end
                mrc_pkg::ADDR_RING:
                begin
                    s_next.ring = 16'(mrc_pkg::mrc_be_merge({16'h0000, s_reg.ring}, avs_writedata_i,
                                                            avs_byteenable_i));
                end
                mrc_pkg::ADDR_STA_LO:
                begin
                    s_next.sta[31:0] = mrc_pkg::mrc_be_merge(s_reg.sta[31:0], avs_writedata_i, avs_byteenable_i);
                end
                mrc_pkg::ADDR_STA_HI:
                begin
                    s_next.sta[47:32] = 16'(mrc_pkg::mrc_be_merge({16'h0000, s_reg.sta[47:32]}, avs_writedata_i,
                                                                  avs_byteenable_i));
                end
                default:
                begin
                    s_next.ctrl = s_reg.ctrl;
                end
            endcase
        end

        // Set wins over a clear in the same cycle
        s_next.thr_eq = thr_eq;
        if (thr_set)
        begin
            s_next.cause = 1'b1;
        end
        s_next.irq = s_next.cause && s_next.mask;
        s_next.desc = s_next.ctrl[mrc_pkg::CTRL_DESC_LO +: 2];

        // Frame admission
        unique case (s_reg.st)
            mrc_pkg::MRC_IDLE:
            begin
                s_next.err = 1'b0;
                if (frame_i.start && frame_i.sfd_ok)
                begin
                    s_next.st = mrc_pkg::MRC_FRAME;
                    s_next.da = frame_i.da;
                    s_next.dma_on = s_reg.ctrl[mrc_pkg::CTRL_EN_BIT];
                end
            end
            mrc_pkg::MRC_FRAME:
            begin
                s_next.err = s_reg.err || frame_i.err;
                if (frame_i.last)
                begin
                    s_next.len = frame_i.len;
                    s_next.st = mrc_pkg::MRC_EVAL;
                end
            end
            mrc_pkg::MRC_EVAL:
            begin
                // Multicast hit was looked up from the latched address a cycle earlier
                if (is_bc)
                begin
                    addr_ok = s_reg.ctrl[mrc_pkg::CTRL_BAM_BIT] || mc_hit;
                end
                else if (is_mc)
                begin
                    addr_ok = s_reg.ctrl[mrc_pkg::CTRL_MPE_BIT] || mc_hit;
                end
                else
                begin
                    addr_ok = s_reg.ctrl[mrc_pkg::CTRL_UPE_BIT] || (s_reg.da == s_reg.sta);
                end
                long_pkt = s_reg.len > mrc_pkg::LONG_LEN;
                len_ok = (s_reg.len <= mrc_pkg::MAX_LEN)
                         && (!long_pkt || s_reg.ctrl[mrc_pkg::CTRL_LPE_BIT]);
                s_next.verdict.stat = 1'b1;
                s_next.verdict.bad = s_reg.err;
                s_next.verdict.long_pkt = long_pkt;
                s_next.verdict.deliver = s_reg.dma_on && addr_ok && len_ok
                                         && (!s_reg.err || s_reg.ctrl[mrc_pkg::CTRL_SBP_BIT]);
                s_next.verdict.drop = !s_next.verdict.deliver;
                s_next.verdict.mng = addr_ok && len_ok && !s_reg.err;
                s_next.st = mrc_pkg::MRC_IDLE;
            end
            default:
            begin
                s_next.st = mrc_pkg::MRC_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            s_reg <= '0;
            s_reg.ctrl <= mrc_pkg::CTRL_RESET;
            s_reg.ring <= mrc_pkg::RING_RESET;
            s_reg.sta <= mrc_pkg::STA_RESET;
            s_reg.st <= mrc_pkg::MRC_IDLE;
            s_reg.waitreq <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign avs_readdata_o = s_reg.rdata;
    assign avs_waitrequest_o = s_reg.waitreq;
    assign verdict_o = s_reg.verdict;
    assign rx_descriptor_format_o = s_reg.desc;
    assign rx_min_threshold_irq_o = s_reg.irq;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_deliver_enabled: assert property (verdict_o.deliver |-> $past(s_reg.dma_on))
        else $error("packet delivered while receiver was disabled");
    chk_enable_held: assert property ((s_reg.st == mrc_pkg::MRC_FRAME && $past(s_reg.st) == mrc_pkg::MRC_FRAME)
                                      |-> $stable(s_reg.dma_on))
        else $error("enable decision changed inside a frame");
    chk_disabled_drop: assert property ((s_reg.st == mrc_pkg::MRC_EVAL && !s_reg.dma_on)
                                        |=> verdict_o.drop && !verdict_o.deliver)
        else $error("frame received while disabled was not dropped");
    chk_stat_counts: assert property ((s_reg.st == mrc_pkg::MRC_EVAL) |=> verdict_o.stat)
        else $error("statistics pulse missing after a frame");
    chk_bad_stored: assert property ((verdict_o.deliver && verdict_o.bad) |-> $past(s_reg.ctrl[2]))
        else $error("bad packet delivered without store enable");
    chk_idle_no_err: assert property ((s_reg.st == mrc_pkg::MRC_IDLE && !(frame_i.start && frame_i.sfd_ok))
                                      |=> !s_reg.err && s_reg.st == mrc_pkg::MRC_IDLE)
        else $error("error outside a frame was taken or frame began without delimiter");
    chk_mng_good: assert property (verdict_o.mng |-> !verdict_o.bad)
        else $error("bad packet sent to manageability");
    chk_long_drop: assert property ((verdict_o.long_pkt && !$past(s_reg.ctrl[5])) |-> !verdict_o.deliver)
        else $error("long packet delivered with long enable clear");
    chk_long_class: assert property (verdict_o.stat
                                     |-> (verdict_o.long_pkt == ($past(s_reg.len) > mrc_pkg::LONG_LEN)))
        else $error("long classification wrong");
    chk_max_len: assert property (verdict_o.deliver |-> $past(s_reg.len) <= mrc_pkg::MAX_LEN)
        else $error("packet above maximum length delivered");
    chk_cause_set: assert property (thr_set |=> s_reg.cause && (s_reg.irq == s_reg.mask))
        else $error("threshold hit did not set the cause");
    chk_irq_mask: assert property (rx_min_threshold_irq_o |-> s_reg.mask && s_reg.cause)
        else $error("interrupt raised while masked");

    cov_deliver: cover property (verdict_o.deliver);
    cov_bad_stored: cover property (verdict_o.deliver && verdict_o.bad);
    cov_disable_mid_frame: cover property (s_reg.st == mrc_pkg::MRC_FRAME && s_reg.dma_on
                                           && !s_reg.ctrl[mrc_pkg::CTRL_EN_BIT] ##[1:20] verdict_o.deliver);
    cov_irq: cover property ($rose(rx_min_threshold_irq_o));

endmodule // mrc_rx_control

// ==== verif/mrc_phy_model.sv ====
// Frame source standing in for the receive decoder in front of the block
// Assumes the bench calls send() from its own sequence, all on clk_i
`timescale 1ns/10ps
module mrc_phy_model (
    // Clock
    input wire logic clk_i,
    // Frame events toward the block
    output mrc_pkg::mrc_frame_s frame_o
);
    // ==========================================================
    // Frame driver
    initial frame_o = '0;

    // Stray error, start, idle gap, end; idle lines carry inverted data, never a stale header
    task automatic send(input logic [47:0] da, input logic [15:0] len, input logic err, input logic sfd,
                        input logic pre, input int gap);
        mrc_pkg::mrc_frame_s f;
        f = '0;
        f.da = ~da;
        if (pre)
        begin
            f.err = 1'b1;
            @(posedge clk_i);
            frame_o <= f;
        end
        f.err = 1'b0;
        f.start = 1'b1;
        f.sfd_ok = sfd;
        f.da = da;
        @(posedge clk_i);
        frame_o <= f;
        f.start = 1'b0;
        f.sfd_ok = 1'b0;
        f.da = ~da;
        repeat (gap) @(posedge clk_i) frame_o <= f;
        f.last = 1'b1;
        f.err = err;
        f.len = len;
        @(posedge clk_i);
        frame_o <= f;
        f.last = 1'b0;
        f.err = 1'b0;
        f.len = ~len;
        @(posedge clk_i);
        frame_o <= f;
    endtask
endmodule // mrc_phy_model

// ==== verif/mrc_rx_control_test.sv ====
// Self-checking bench for the receive control block: register access and frame verdicts
// Assumes the frame model above and the Avalon timing of one wait cycle per access
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module mrc_rx_control_test;
    logic clk_i;
    logic sys_rst_i;
    logic [15:0] avs_address_i;
    logic avs_read_i;
    logic avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0] avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    mrc_pkg::mrc_frame_s frame_i;
    logic [15:0] free_desc_i;
    mrc_pkg::mrc_verdict_s verdict_o;
    logic [1:0] rx_descriptor_format_o;
    logic rx_min_threshold_irq_o;
    int mismatches = 0;
    int num_checks = 0;
    logic [31:0] q;
    logic [47:0] da;
    logic [11:0] idx;
    logic saw;
    localparam logic [31:0] EN = 32'h00000002;
    localparam logic [47:0] UC = 48'h102233445566;
    localparam int LO[4] = '{36, 35, 34, 32};

    // ==========================================================
    // Design, frame source and clock
    mrc_rx_control dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .frame_i(frame_i), .free_desc_i(free_desc_i),
        .verdict_o(verdict_o), .rx_descriptor_format_o(rx_descriptor_format_o),
        .rx_min_threshold_irq_o(rx_min_threshold_irq_o));
    mrc_phy_model phy (.clk_i(clk_i), .frame_o(frame_i));

    // 125 MHz core clock
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ==========================================================
    // Verdict and run end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Avalon access: hold everything until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (avs_waitrequest_o !== 1'b0 && n < 20);
        if (avs_waitrequest_o !== 1'b0)
        begin
            mismatches++;
            complete_run();
        end
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    // One frame, then wait for its verdict pulse; a missing pulse also means stats did not count
    task automatic frame(input logic [47:0] d, input logic [15:0] len, input logic err, input logic pre,
                         input int gap, input logic exp);
        int n;
        phy.send(d, len, err, 1'b1, pre, gap);
        n = 0;
        while (verdict_o.stat !== 1'b1 && n < 8)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (verdict_o.stat !== 1'b1)
        begin
            mismatches++;
            complete_run();
        end
        `CHK(verdict_o.deliver, exp)
        `CHK(verdict_o.drop, !exp)
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        sys_rst_i = 1'b1;
        avs_address_i = '0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = '0;
        avs_byteenable_i = 4'hF;
        free_desc_i = 16'hFFFF;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        // Reset value, reserved bits dropped, unmapped place reads zero
        bus(0, mrc_pkg::ADDR_CTRL, 0);
        `CHK(q, 32'h00000000)
        bus(1, mrc_pkg::ADDR_CTRL, 32'hFFFFFFFE);
        bus(0, mrc_pkg::ADDR_CTRL, 0);
        `CHK(q, mrc_pkg::CTRL_WR_MASK)
        bus(0, 16'h0200, 0);
        `CHK(q, 32'h00000000)
        bus(1, mrc_pkg::ADDR_CTRL, 32'h00000400);
        @(posedge clk_i);
        #1;
        `CHK(rx_descriptor_format_o, mrc_pkg::DESC_SPLIT)
        $display("registers done");
        // Unicast, enable, store-bad, stray error, long packets
        bus(1, mrc_pkg::ADDR_STA_LO, 32'h33445566);
        bus(1, mrc_pkg::ADDR_STA_HI, 32'h00001022);
        frame(UC, 16'd64, 0, 0, 0, 1'b0);
        `CHK(verdict_o.mng, 1'b1)
        bus(1, mrc_pkg::ADDR_CTRL, EN);
        frame(UC, 16'd64, 0, 0, 0, 1'b1);
        frame(48'h0022AABBCCDD, 16'd64, 0, 0, 0, 1'b0);
        frame(UC, 16'd64, 0, 1, 0, 1'b1);
        `CHK(verdict_o.bad, 1'b0)
        frame(UC, 16'd64, 1, 0, 0, 1'b0);
        `CHK(verdict_o.bad, 1'b1)
        bus(1, mrc_pkg::ADDR_CTRL, EN | 32'h0000000C);
        frame(48'h0022AABBCCDD, 16'd64, 0, 0, 0, 1'b1);
        frame(UC, 16'd64, 1, 0, 0, 1'b1);
        `CHK(verdict_o.mng, 1'b0)
        frame(UC, 16'd1522, 0, 0, 0, 1'b1);
        `CHK(verdict_o.long_pkt, 1'b0)
        frame(UC, 16'd1523, 0, 0, 0, 1'b0);
        `CHK(verdict_o.long_pkt, 1'b1)
        bus(1, mrc_pkg::ADDR_CTRL, EN | 32'h00000020);
        frame(UC, 16'd16384, 0, 0, 0, 1'b1);
        frame(UC, 16'd16385, 0, 0, 0, 1'b0);
        phy.send(UC, 16'd64, 0, 1'b0, 0, 1);
        saw = 1'b0;
        repeat (6) @(posedge clk_i) saw = saw | verdict_o.stat;
        `CHK(saw, 1'b0)
        // Enable cleared while a frame is in flight
        fork
            frame(UC, 16'd64, 0, 0, 6, 1'b1);
            bus(1, mrc_pkg::ADDR_CTRL, 0);
        join
        frame(UC, 16'd64, 0, 0, 0, 1'b0);
        $display("frames done");
        // Every multicast offset: hit with the one table bit set, miss once it is cleared
        for (int c = 0; c < 4; c++)
        begin
            bus(1, mrc_pkg::ADDR_CTRL, EN | (32'(c) << 12));
            da = (48'h0000000005A3 << LO[c]) | 48'h010000000000;
            idx = da[LO[c] +: 12];
            bus(1, mrc_pkg::ADDR_MTA + {4'h0, idx[11:5], 2'b00}, 32'h00000001 << idx[4:0]);
            frame(da, 16'd64, 0, 0, 0, 1'b1);
            bus(1, mrc_pkg::ADDR_MTA + {4'h0, idx[11:5], 2'b00}, 32'h00000000);
            frame(da, 16'd64, 0, 0, 0, 1'b0);
        end
        bus(1, mrc_pkg::ADDR_CTRL, EN | 32'h00000010);
        frame(da, 16'd64, 0, 0, 0, 1'b1);
        $display("multicast done");
        // Threshold codes over a ring of 64: cause, unmasked interrupt, clear
        bus(1, mrc_pkg::ADDR_RING, 32'h00000040);
        bus(1, mrc_pkg::ADDR_MASK, 32'h00000010);
        for (int c = 0; c < 4; c++)
        begin
            bus(1, mrc_pkg::ADDR_CTRL, 32'(c) << 8);
            free_desc_i <= 16'd64 >> (c + 1);
            repeat (3) @(posedge clk_i);
            #1;
            `CHK(rx_min_threshold_irq_o, 1'(c != 3))
            bus(0, mrc_pkg::ADDR_CAUSE, 0);
            `CHK(q[4], 1'(c != 3))
            bus(1, mrc_pkg::ADDR_CAUSE, 32'h00000010);
            bus(0, mrc_pkg::ADDR_CAUSE, 0);
            `CHK(q[4], 1'b0)
            free_desc_i <= 16'hFFFF;
        end
        // Masked: the cause still sets but the interrupt stays low
        bus(1, mrc_pkg::ADDR_MASK, 32'h00000000);
        bus(1, mrc_pkg::ADDR_CTRL, 32'h00000000);
        free_desc_i <= 16'd32;
        repeat (3) @(posedge clk_i);
        #1;
        `CHK(rx_min_threshold_irq_o, 1'b0)
        bus(0, mrc_pkg::ADDR_CAUSE, 0);
        `CHK(q[4], 1'b1)
        $display("threshold done");
        complete_run();
    end
endmodule // mrc_rx_control_test
